// *** core/lscd_core.v ***
// Serial frame decoder, display RAM and configuration state
`timescale 1ns/100ps
`include "lscd_defs.vh"

// How it works
// - Read frame: 110, eight address bits MSB first, four data bits out LSB first.
// - Write frame: 101, eight address bits MSB first, four data bits in LSB first.
// - Read-then-update under 101: stored nibble goes out, replacement nibble comes in.
// - Identifiers 110, 101, 100 choose mode; 100 means nine-bit commands, X ignored.
// - Command mode keeps decoding nine-bit groups until chip select rises.
// - Code 0000-0000 stops oscillator and bias; that is the reset state.
// - Code 0000-0001 starts the oscillator, other settings untouched.
// - Code 0000-0010 blanks the display (default); 0000-0011 shows it.
// - Code 0000-0100 disables time base (default); 0000-0110 enables it.
// - Code 0000-0101 disables watchdog flag (default); 0000-0111 enables it.
// - Code 0000-1000 silences both buzzer outputs; silent after reset.
// - Code 0000-1101 clears the time base counter.
// - Code 0000-1111 clears the watchdog stage.
// - Code 0001-10XX selects internal oscillator (default); 0001-11XX external clock.
// - Code 010X sets 4 kHz tone; 0110 sets 2 kHz tone.
// - Code 101X-0nnn sets time base 2^n Hz, watchdog 4 s over 2^n; default n=7.
// - Code 1110-0000 enters test mode; 1110-0011 restores normal (default).
// - Tone and timer derive from the selected internal or external 32 kHz source.
// - Chip select high abandons the mode; a fresh identifier must follow.
// - Watchdog time-out holds interrupt low until watchdog clear or interrupt disable.
// - Time base and watchdog share one divide-by-256 prescaler.
module lscd_core #(
  parameter RAM_DEPTH = 192,
  parameter ADDR_W = 8
) (
  input wire clk,
  input wire rst_b,
  input wire cs_b,
  input wire wr_b,
  input wire rd_b,
  input wire data_in,
  output reg data_out,
  output wire data_oe,
  input wire rc_tick,
  input wire ext_tick,
  output reg osc_on,
  output reg bias_on,
  output reg display_on,
  output reg ext_src,
  output reg test_mode,
  output reg irq_b,
  output reg buzzer_out,
  output reg buzzer_out_b
);

  localparam S_ID = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_WR = 3'h2;
  localparam S_RD = 3'h3;
  localparam S_RMW = 3'h4;
  localparam S_CMD = 3'h5;
  localparam S_LOST = 3'h6;

  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [1:0] id_sh;
  reg read_frame;
  reg [ADDR_W-1:0] addr;
  reg [3:0] wr_sh;
  reg [3:0] rd_sh;
  reg [7:0] cmd_sh;
  reg wr_prev;
  reg rd_prev;
  reg [3:0] ram [0:RAM_DEPTH-1];

  reg tb_en;
  reg wd_en;
  reg tone_on;
  reg pitch_hi;
  reg irq_en;
  reg [2:0] rate;
  reg tb_clear;
  reg wd_clear;

  wire wr_rise;
  wire rd_rise;
  wire rd_fall;
  wire [2:0] id_full;
  wire [ADDR_W-1:0] addr_full;
  wire [3:0] nib_full;
  wire nib_done;
  wire cmd_done;
  wire [3:0] ram_q;
  wire osc_run;
  wire sys_tick;
  wire tb_level;
  wire wd_flag;
  wire tone;

  // Strobes are synchronous to clk, so one stage finds their edges
  assign wr_rise = wr_b & ~wr_prev & ~cs_b;
  assign rd_rise = rd_b & ~rd_prev & ~cs_b;
  assign rd_fall = ~rd_b & rd_prev & ~cs_b;

  // Shift words as they will look after the current bit lands
  assign id_full = {id_sh, data_in};
  assign addr_full = {addr[ADDR_W-2:0], data_in};
  assign nib_full = {data_in, wr_sh[3:1]};
  assign nib_done = wr_rise && state == S_WR && bit_cnt == `LSCD_DATA_LAST;
  assign cmd_done = wr_rise && state == S_CMD && bit_cnt == `LSCD_CMD_LAST;

  // Holes above the populated depth read as zero
  assign ram_q = (addr < RAM_DEPTH) ? ram[addr] : 4'h0;

  // Data pin is driven only in a read phase with the chip selected
  assign data_oe = ~cs_b & (state == S_RD || state == S_RMW);

  // External clock keeps running, so power-down cannot stop it
  assign osc_run = osc_on | ext_src;
  assign sys_tick = ext_src ? ext_tick : rc_tick;

  always @(posedge clk) begin
    if (!rst_b) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= wr_b;
      rd_prev <= rd_b;
    end
  end

  // Frame sequencer; chip select high always drops back to ID
  always @(posedge clk) begin
    if (!rst_b || cs_b) begin
      state <= S_ID;
      bit_cnt <= 4'h0;
      id_sh <= 2'h0;
      read_frame <= 1'b0;
      addr <= {ADDR_W{1'b0}};
      wr_sh <= 4'h0;
      rd_sh <= 4'h0;
      cmd_sh <= 8'h00;
    end else begin
      case (state)
        S_ID: begin
          if (wr_rise) begin
            id_sh <= id_full[1:0];
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LSCD_ID_LAST) begin
              bit_cnt <= 4'h0;
              read_frame <= (id_full == `LSCD_ID_READ);
              case (id_full)
                `LSCD_ID_READ: state <= S_ADDR;
                `LSCD_ID_WRITE: state <= S_ADDR;
                `LSCD_ID_CMD: state <= S_CMD;
                default: state <= S_LOST;
              endcase
            end
          end
        end
        S_ADDR: begin
          if (wr_rise) begin
            addr <= addr_full;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LSCD_ADDR_LAST) begin
              bit_cnt <= 4'h0;
              state <= read_frame ? S_RD : S_WR;
            end
          end
        end
        S_WR: begin
          if (wr_rise) begin
            wr_sh <= nib_full;
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LSCD_DATA_LAST) begin
              bit_cnt <= 4'h0;
              addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
            end
          end else if (rd_fall && bit_cnt == 4'h0) begin
            // Read strobe before any data bit turns this into a read-then-update
            rd_sh <= ram_q;
            state <= S_RMW;
          end
        end
        S_RD, S_RMW: begin
          if (rd_fall && bit_cnt == 4'h0) begin
            rd_sh <= ram_q;
          end else if (rd_rise) begin
            rd_sh <= {1'b0, rd_sh[3:1]};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LSCD_DATA_LAST) begin
              bit_cnt <= 4'h0;
              if (state == S_RMW) begin
                state <= S_WR;
              end else begin
                addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
              end
            end
          end
        end
        S_CMD: begin
          if (wr_rise) begin
            cmd_sh <= {cmd_sh[6:0], data_in};
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `LSCD_CMD_LAST) begin
              bit_cnt <= 4'h0;
            end
          end
        end
        // Unknown identifier: ignore everything until deselect
        default: state <= S_LOST;
      endcase
    end
  end

  // Read data pin comes from a flop, LSB of the nibble first
  always @(posedge clk) begin
    if (!rst_b) begin
      data_out <= 1'b0;
    end else begin
      data_out <= rd_sh[0];
    end
  end

  // Display RAM holds no reset; software owns its contents
  always @(posedge clk) begin
    if (nib_done && addr < RAM_DEPTH) begin
      ram[addr] <= nib_full;
    end
  end

  // Command decode on the ninth bit; last bit is don't-care
  always @(posedge clk) begin
    if (!rst_b) begin
      osc_on <= `LSCD_DEF_OSC;
      bias_on <= `LSCD_DEF_BIAS;
      display_on <= `LSCD_DEF_DISPLAY;
      tb_en <= `LSCD_DEF_TB_EN;
      wd_en <= `LSCD_DEF_WD_EN;
      tone_on <= `LSCD_DEF_TONE_ON;
      pitch_hi <= `LSCD_DEF_PITCH_HI;
      ext_src <= `LSCD_DEF_EXT_SRC;
      irq_en <= `LSCD_DEF_IRQ_EN;
      rate <= `LSCD_DEF_RATE;
      test_mode <= `LSCD_DEF_TEST;
      tb_clear <= 1'b0;
      wd_clear <= 1'b0;
    end else begin
      tb_clear <= 1'b0;
      wd_clear <= 1'b0;
      if (cmd_done) begin
        casez (cmd_sh)
          8'h00: begin
            osc_on <= 1'b0;
            bias_on <= 1'b0;
          end
          8'h01: osc_on <= 1'b1;
          8'h02: begin
            display_on <= 1'b0;
            bias_on <= 1'b0;
          end
          8'h03: begin
            display_on <= 1'b1;
            bias_on <= 1'b1;
          end
          8'h04: tb_en <= 1'b0;
          8'h06: tb_en <= 1'b1;
          8'h05: wd_en <= 1'b0;
          8'h07: wd_en <= 1'b1;
          8'h08: tone_on <= 1'b0;
          8'h0d: tb_clear <= 1'b1;
          8'h0f: wd_clear <= 1'b1;
          8'b0001_10??: ext_src <= 1'b0;
          8'b0001_11??: ext_src <= 1'b1;
          8'b010?_????: begin
            tone_on <= 1'b1;
            pitch_hi <= 1'b1;
          end
          8'b0110_????: begin
            tone_on <= 1'b1;
            pitch_hi <= 1'b0;
          end
          8'b100?_0???: begin
            irq_en <= 1'b0;
            wd_clear <= 1'b1;
          end
          8'b100?_1???: irq_en <= 1'b1;
          8'b101?_0???: rate <= cmd_sh[2:0];
          8'he0: test_mode <= 1'b1;
          8'he3: test_mode <= 1'b0;
          default: test_mode <= test_mode;
        endcase
      end
    end
  end

  // Timer chain runs only while a clock source is alive
  lscd_timer u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .tick(sys_tick),
    .run(osc_run),
    .rate(rate),
    .tb_clear(tb_clear),
    .wd_clear(wd_clear),
    .pitch_hi(pitch_hi),
    .tb_level(tb_level),
    .wd_flag(wd_flag),
    .tone(tone)
  );

  // Interrupt pin: time base square wave or latched watchdog flag
  always @(posedge clk) begin
    if (!rst_b) begin
      irq_b <= 1'b1;
    end else begin
      irq_b <= ~(irq_en & ((tb_en & tb_level) | (wd_en & wd_flag)));
    end
  end

  // Differential buzzer pair; both low when silent to save current
  always @(posedge clk) begin
    if (!rst_b) begin
      buzzer_out <= 1'b0;
      buzzer_out_b <= 1'b0;
    end else begin
      buzzer_out <= tone_on & osc_run & tone;
      buzzer_out_b <= tone_on & osc_run & ~tone;
    end
  end

endmodule // lscd_core

// *** inc/lscd_defs.vh ***
// Shared constants for the serial command decoder and its timer
`ifndef LSCD_DEFS_VH
`define LSCD_DEFS_VH

// Three-bit mode identifiers
`define LSCD_ID_READ 3'h6
`define LSCD_ID_WRITE 3'h5
`define LSCD_ID_CMD 3'h4

// Frame field lengths, counted from zero
`define LSCD_ID_LAST 4'h2
`define LSCD_ADDR_LAST 4'h7
`define LSCD_DATA_LAST 4'h3
`define LSCD_CMD_LAST 4'h8

// Power-on defaults of the configuration bits
`define LSCD_DEF_OSC 1'b0
`define LSCD_DEF_BIAS 1'b0
`define LSCD_DEF_DISPLAY 1'b0
`define LSCD_DEF_TB_EN 1'b0
`define LSCD_DEF_WD_EN 1'b0
`define LSCD_DEF_TONE_ON 1'b0
`define LSCD_DEF_PITCH_HI 1'b0
`define LSCD_DEF_EXT_SRC 1'b0
`define LSCD_DEF_IRQ_EN 1'b0
`define LSCD_DEF_RATE 3'h7
`define LSCD_DEF_TEST 1'b0

// Timer chain: prescaler of 256 plus seven divider stages
`define LSCD_CHAIN_W 15
`define LSCD_TOP_BIT 4'he
`define LSCD_TONE_HI_BIT 2
`define LSCD_TONE_LO_BIT 3
`define LSCD_WD_LAST 2'h3

`endif

// *** core/lscd_timer.v ***
// Shared prescaler, time base, watchdog stage and tone divider
`timescale 1ns/100ps
`include "lscd_defs.vh"

module lscd_timer #(
  parameter CHAIN_W = `LSCD_CHAIN_W
) (
  input wire clk,
  input wire rst_b,
  input wire tick,
  input wire run,
  input wire [2:0] rate,
  input wire tb_clear,
  input wire wd_clear,
  input wire pitch_hi,
  output reg tb_level,
  output reg wd_flag,
  output reg tone
);

  reg [CHAIN_W-1:0] chain;
  reg [1:0] wd_stage;
  reg tb_prev;
  wire [3:0] tb_bit;
  wire tb_sel;
  wire period_end;

  // Rate n picks the chain bit toggling at 2^n Hz
  assign tb_bit = `LSCD_TOP_BIT - {1'b0, rate};
  assign tb_sel = chain[tb_bit];
  assign period_end = tb_prev & ~tb_sel;

  // One counter: low eight bits are the shared prescaler
  always @(posedge clk) begin
    if (!rst_b) begin
      chain <= {CHAIN_W{1'b0}};
    end else if (tb_clear) begin
      chain <= {CHAIN_W{1'b0}};
    end else if (run && tick) begin
      chain <= chain + {{(CHAIN_W-1){1'b0}}, 1'b1};
    end
  end

  // Watchdog counts four time-base periods, so 4 s at 1 Hz
  always @(posedge clk) begin
    if (!rst_b) begin
      tb_prev <= 1'b0;
      wd_stage <= 2'h0;
      wd_flag <= 1'b0;
    end else begin
      tb_prev <= tb_sel;
      if (wd_clear) begin
        wd_stage <= 2'h0;
      end else if (period_end) begin
        wd_stage <= wd_stage + 2'h1;
      end
      // Set wins over a clear in the same cycle
      wd_flag <= (period_end && wd_stage == `LSCD_WD_LAST) | (wd_flag & ~wd_clear);
    end
  end

  // Registered outputs so the pins never glitch
  always @(posedge clk) begin
    if (!rst_b) begin
      tb_level <= 1'b0;
      tone <= 1'b0;
    end else begin
      tb_level <= tb_sel;
      tone <= pitch_hi ? chain[`LSCD_TONE_HI_BIT] : chain[`LSCD_TONE_LO_BIT];
    end
  end

endmodule // lscd_timer

// *** tb/lscd_core_assertions.sv ***
// Port-level checks on the serial command decoder
`timescale 1ns/100ps
module lscd_core_chk (
  input wire clk,
  input wire rst_b,
  input wire cs_b,
  input wire wr_b,
  input wire rd_b,
  input wire data_out,
  input wire data_oe,
  input wire osc_on,
  input wire bias_on,
  input wire display_on,
  input wire ext_src,
  input wire test_mode,
  input wire irq_b,
  input wire buzzer_out,
  input wire buzzer_out_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Defaults on the first edge out of reset
  property p_rst_cfg; $rose(rst_b) |-> !osc_on && !bias_on && !display_on; endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("reset config wrong");
  property p_rst_src; $rose(rst_b) |-> !ext_src && !test_mode && !buzzer_out; endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source wrong");
  property p_rst_irq; $rose(rst_b) |-> irq_b; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("reset irq wrong");
  // Tone pair never both high
  property p_bz_pair; !(buzzer_out && buzzer_out_b); endproperty
  a_bz_pair: assert property (p_bz_pair) else $error("buzzer pair both high");
  // Pin driven only while selected
  property p_oe_cs; data_oe |-> !cs_b; endproperty
  a_oe_cs: assert property (p_oe_cs) else $error("drive while deselected");
  property p_oe_start; $rose(data_oe) |-> !$past(cs_b); endproperty
  a_oe_start: assert property (p_oe_start) else $error("drive without frame");
  // Settings move only after a taken write strobe
  property p_cfg_hold;
    (cs_b || !wr_b || $past(wr_b)) |=> $stable({osc_on, display_on, ext_src, test_mode});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved without strobe");
  // Read bit holds between read strobe edges
  property p_dout_hold;
    data_oe && $past(data_oe) && ($past(rd_b) == $past(rd_b, 2)) |=> $stable(data_out);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("read bit moved");
endmodule // lscd_core_chk

bind lscd_core lscd_core_chk lscd_core_chk_i (
  .clk(clk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b),
  .data_out(data_out), .data_oe(data_oe), .osc_on(osc_on), .bias_on(bias_on),
  .display_on(display_on), .ext_src(ext_src), .test_mode(test_mode), .irq_b(irq_b),
  .buzzer_out(buzzer_out), .buzzer_out_b(buzzer_out_b)
);

// *** tb/lscd_host.sv ***
// Host model driving the four-wire serial link
`timescale 1ns/100ps
module lscd_host (
  input wire clk,
  input wire data_out,
  input wire data_oe,
  output reg cs_b,
  output reg wr_b,
  output reg rd_b,
  output wire pin,
  output reg done,
  output reg [3:0] nib
);
  reg drv;
  // Shared data line, device wins during its read phase
  assign pin = data_oe ? data_out : drv;
  initial begin
    cs_b = 1'b1;
    wr_b = 1'b1;
    rd_b = 1'b1;
    drv = 1'b0;
    done = 1'b0;
    nib = 4'h0;
  end
  // One bit, taken on the strobe rise; inverse shown once hold is over
  task wbit(input b);
    drv = b;
    wr_b = 1'b0;
    repeat (2) @(negedge clk);
    wr_b = 1'b1;
    @(negedge clk);
    // Inverse after hold; a full clock passes before the next bit is set
    drv = ~b;
    @(negedge clk);
  endtask
  task w3(input [2:0] v);
    for (int i = 2; i >= 0; i--) wbit(v[i]);
  endtask
  task w8(input [7:0] v);
    for (int i = 7; i >= 0; i--) wbit(v[i]);
  endtask
  task w9(input [8:0] v);
    for (int i = 8; i >= 0; i--) wbit(v[i]);
  endtask
  task w4(input [3:0] v);
    for (int i = 0; i < 4; i++) wbit(v[i]);
  endtask
  // Nibble back, least significant bit first
  task r4;
    for (int i = 0; i < 4; i++) begin
      rd_b = 1'b0;
      repeat (3) @(negedge clk);
      nib[i] = pin;
      rd_b = 1'b1;
      repeat (3) @(negedge clk);
    end
  endtask
  // Frame edge only; no identifier is sent with the select, the caller sends it
  task sel(input b);
    cs_b = b;
    repeat (2) @(negedge clk);
  endtask
  task probe;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
endmodule // lscd_host

// *** tb/lscd_core_test.sv ***
// Self-checking bench for the serial command decoder
`timescale 1ns/100ps
module lscd_core_test;
  reg clk = 1'b0;
  reg rst_b = 1'b0;
  reg rc_tick = 1'b0;
  reg ext_tick = 1'b0;
  wire cs_b, wr_b, rd_b, pin, data_out, data_oe, osc_on, bias_on, display_on;
  wire ext_src, test_mode, irq_b, buzzer_out, buzzer_out_b, done;
  wire [3:0] nib;
  integer seed = 30;
  integer fail_count = 0;
  integer checked = 0;
  integer cycles = 0;
  integer lows = 0;
  integer base = 0;
  integer hums = 0;
  integer hums_b = 0;
  reg [12:0] expq[$];
  reg [12:0] e;
  reg [8:0] st;
  reg [7:0] a;
  reg [3:0] d, d2, d3, x;
  reg [7:0] codes [0:9] = '{8'h01, 8'h40, 8'h60, 8'h0d, 8'h0f, 8'h07, 8'h05, 8'ha7, 8'h06, 8'h88};
  initial forever #20 clk = ~clk;
  lscd_core lscd_core_i (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b),
    .data_in(pin), .data_out(data_out), .data_oe(data_oe), .rc_tick(rc_tick),
    .ext_tick(ext_tick), .osc_on(osc_on), .bias_on(bias_on), .display_on(display_on),
    .ext_src(ext_src), .test_mode(test_mode), .irq_b(irq_b), .buzzer_out(buzzer_out),
    .buzzer_out_b(buzzer_out_b));
  lscd_host lscd_host_i (.clk(clk), .data_out(data_out), .data_oe(data_oe), .cs_b(cs_b),
    .wr_b(wr_b), .rd_b(rd_b), .pin(pin), .done(done), .nib(nib));
  task chk(input [12:0] seen, input [12:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED result expected %h seen %h", exp, seen);
    end
  endtask
  task summarize;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task note(input [3:0] n);
    expq.push_back({n, st});
    lscd_host_i.probe;
  endtask
  task start(input [2:0] id);
    lscd_host_i.sel(1'b0);
    lscd_host_i.w3(id);
  endtask
  task cmd(input [8:0] c);
    lscd_host_i.w9(c);
  endtask
  // Source ticks, interrupt watch and hang limit
  always @(negedge clk) begin
    cycles = cycles + 1;
    rc_tick <= (cycles % 4 == 0);
    ext_tick <= (cycles % 3 == 0);
    if (irq_b === 1'b0) lows = lows + 1;
    if (buzzer_out === 1'b1) hums = hums + 1;
    if (buzzer_out_b === 1'b1) hums_b = hums_b + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  // Oldest note against what the outputs show now
  // Looked at after the edge has settled, not in its own time step
  always @(posedge clk) if (done === 1'b1) begin
    #2;
    e = expq.pop_front();
    chk({nib, osc_on, bias_on, display_on, ext_src, test_mode, irq_b, lows > base, hums > 0,
      hums_b > 0}, e);
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    st = 9'h008;
    note(4'h0);
    // Several commands after one identifier, don't-care bits random
    x = $random(seed);
    start(3'h4);
    cmd({8'h01, x[0]});
    cmd({8'h03, x[1]});
    cmd({6'h07, x[2:1], x[0]});
    cmd({8'he0, x[3]});
    lscd_host_i.sel(1'b1);
    st = 9'h1f8;
    note(4'h0);
    // Every setting changed above rewritten to its default
    start(3'h4);
    cmd({8'he3, x[0]});
    cmd({6'h06, x[3:1]});
    cmd({8'h02, x[2]});
    cmd({8'h00, x[1]});
    lscd_host_i.sel(1'b1);
    st = 9'h008;
    note(4'h0);
    // Time base drives the interrupt low, then it is disabled
    base = lows;
    start(3'h4);
    for (int k = 0; k < 10; k++) cmd({codes[k], x[k % 4]});
    lscd_host_i.sel(1'b1);
    repeat (1500) @(negedge clk);
    start(3'h4);
    cmd(9'h100);
    cmd(9'h010);
    lscd_host_i.sel(1'b1);
    st = 9'h10f;
    note(4'h0);
    // Frame cut short; bits without identifier must be ignored
    start(3'h4);
    lscd_host_i.w4(4'h0);
    lscd_host_i.sel(1'b1);
    lscd_host_i.sel(1'b0);
    cmd(9'h006);
    lscd_host_i.sel(1'b1);
    note(4'h0);
    // Writes, auto-increment reads and read-then-update
    for (int k = 0; k < 3; k++) begin
      a = $random(seed);
      if (a > 8'hbe) a = a - 8'h50;
      {d, d2, d3} = $random(seed);
      start(3'h5);
      lscd_host_i.w8(a);
      lscd_host_i.w4(d);
      lscd_host_i.w4(d2);
      lscd_host_i.sel(1'b1);
      start(3'h6);
      lscd_host_i.w8(a);
      lscd_host_i.r4;
      note(d);
      lscd_host_i.r4;
      note(d2);
      lscd_host_i.sel(1'b1);
      start(3'h5);
      lscd_host_i.w8(a);
      lscd_host_i.r4;
      note(d);
      lscd_host_i.w4(d3);
      lscd_host_i.sel(1'b1);
      start(3'h6);
      lscd_host_i.w8(a);
      lscd_host_i.r4;
      note(d3);
      lscd_host_i.sel(1'b1);
    end
    summarize;
  end
endmodule // lscd_core_test
